// ---- hw/itc_top.sv ----
// interrupt and trap front end with clearing latencies and core standby
//
// Summary of operation
// - writing one clears that pending bit
// - taking an interrupt clears only its bit
// - command bits 15:12 decode 4/5/6 commands
// - input length update drops request after 4
// - unit reset clears full, sets empty, 6
// - demux read or input flush clears input
// - output flush or collision clear clears requests
// - four interrupt pins, trap pin input at reset
// - trap forced through own vector, unmaskable
// - pins latched on falling clock edge
// - service no sooner than four cycles, waits extend all but trap entry
// - vector code out and acknowledge on entry
// - trap entry within three further instructions
// - standby stops core clock, peripherals run
// - aux flag bit 15 requests standby
// - one more instruction before core stops
// - interrupt in standby clears bit, resumes
// - dma units keep running in standby
// - writing zero leaves pending bit alone
// - equal priority picks lowest vector first
// - vector code all ones while idle
//
// Implementation choices: the address-and-strobe port and the register addresses.
module itc_top
   import itc_pkg::*;
#(
   parameter int NUNIT = 2,
   parameter int NEXT = 4
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [ITC_AW-1:0] addr_i,
   input wire logic [ITC_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [ITC_DW-1:0] rdata_o,
   input wire logic [NEXT-1:0] ext_irq_i,
   input wire logic trap_in_i,
   output logic trap_out_o,
   output logic trap_oe_n_o,
   input wire logic [1:0] timer_irq_i,
   input wire logic [NUNIT-1:0] dma_input_full_set_i,
   input wire logic [NUNIT-1:0] dma_output_empty_set_i,
   input wire logic serial_input_full_set_i,
   input wire logic serial_input_frame_error_set_i,
   input wire logic serial_output_empty_set_i,
   input wire logic serial_output_frame_error_set_i,
   input wire logic serial_collision_set_i,
   input wire logic core_wait_i,
   input wire logic core_instr_i,
   input wire logic ireturn_i,
   output logic [3:0] vector_code_o,
   output logic irq_acknowledge_o,
   output logic core_run_o,
   output logic periph_run_o,
   output logic [NUNIT-1:0] dma_input_full_o,
   output logic [NUNIT-1:0] dma_output_empty_o,
   output logic serial_input_full_o,
   output logic serial_output_empty_o
);

   typedef struct packed {
      logic [15:0] pend;
      logic [15:0] mask;
      logic [NUNIT-1:0] din;
      logic [NUNIT-1:0] dout;
      logic sin_full;
      logic sin_ferr;
      logic sout_empty;
      logic sout_ferr;
      logic scoll;
      logic trap_lat;
      itc_fsm_t fsm;
      logic [2:0] cnt;
      logic cur_trap;
      logic [3:0] vec;
      logic ack;
      logic stby_req;
      logic stby_armed;
      logic core_run;
      logic periph_run;
      logic trap_oe_n;
      logic [ITC_DW-1:0] rdata;
   } itc_st_t;

   itc_st_t s;
   itc_st_t next_s;
   logic [NEXT-1:0] ext_neg;
   logic trap_neg;
   logic [15:0] active;
   logic [3:0] pick;
   logic pick_ok;

   itc_clr_if #(.W(ITC_NCLR), .D(ITC_PIPE_D)) cp ();

   itc_clr_pipe #(.W(ITC_NCLR), .D(ITC_PIPE_D)) u_pipe (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .cp(cp)
   );

   // ****************************************
   // falling edge pin latch
   // ****************************************
   always_ff @(negedge clock_i) begin
      if (rst_i) begin
         ext_neg <= '0;
         trap_neg <= 1'b0;
      end else if (ce_i) begin
         ext_neg <= ext_irq_i;
         trap_neg <= trap_in_i;
      end
   end

   // ****************************************
   // clear event decode
   // ****************************************
   always_comb begin
      cp.clr = '0;
      for (int u = 0; u < NUNIT; u++) begin
         if (wr_i && addr_i == ITC_A_DCMD0 + 4'(u)) begin
            case (wdata_i[ITC_CMD_HI:ITC_CMD_LO])
               ITC_CMD_ILEN: cp.clr[ITC_C_ILEN0 + ITC_C_UNIT*u] = 1'b1;
               ITC_CMD_OLEN: cp.clr[ITC_C_OLEN0 + ITC_C_UNIT*u] = 1'b1;
               ITC_CMD_RST: cp.clr[ITC_C_RST0 + ITC_C_UNIT*u] = 1'b1;
               default: ;
            endcase
         end
      end
      if ((rd_i && addr_i == ITC_A_DEMUX) ||
          (wr_i && addr_i == ITC_A_ICTL && wdata_i[ITC_FLUSH_BIT])) begin
         cp.clr[ITC_C_SIN] = 1'b1;
      end
      if ((wr_i && addr_i == ITC_A_OMUX) ||
          (wr_i && addr_i == ITC_A_OCTL &&
           (wdata_i[ITC_FLUSH_BIT] || wdata_i[ITC_COLL_BIT]))) begin
         cp.clr[ITC_C_SOUT] = 1'b1;
      end
      if (wr_i && addr_i == ITC_A_OCTL &&
          (wdata_i[ITC_FLUSH_BIT] || wdata_i[ITC_COLL_BIT])) begin
         cp.clr[ITC_C_OCTL] = 1'b1;
      end
   end

   // ****************************************
   // priority: lowest vector code wins
   // ****************************************
   always_comb begin
      active = s.pend & s.mask & ITC_PEND_VALID;
      pick = 4'h0;
      pick_ok = 1'b0;
      for (int b = 15; b >= 1; b--) begin
         if (active[b]) begin
            pick = 4'(b);
            pick_ok = 1'b1;
         end
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [15:0] setv;
      logic [15:0] clrv;
      logic ser_hold;
      setv = '0;
      clrv = '0;
      ser_hold = 1'b0;
      next_s = s;

      // request latches with their clearing latencies
      for (int u = 0; u < NUNIT; u++) begin
         if (cp.stage[ITC_LAT_LEN-1][ITC_C_ILEN0 + ITC_C_UNIT*u] ||
             cp.stage[ITC_LAT_DRST-1][ITC_C_RST0 + ITC_C_UNIT*u]) begin
            next_s.din[u] = 1'b0;
         end
         if (cp.stage[ITC_LAT_LEN-1][ITC_C_OLEN0 + ITC_C_UNIT*u]) begin
            next_s.dout[u] = 1'b0;
         end
         if (cp.stage[ITC_LAT_DRST-1][ITC_C_RST0 + ITC_C_UNIT*u]) begin
            next_s.dout[u] = 1'b1;
         end
         if (dma_input_full_set_i[u]) begin
            next_s.din[u] = 1'b1;
         end
         if (dma_output_empty_set_i[u]) begin
            next_s.dout[u] = 1'b1;
         end
      end
      if (cp.stage[ITC_LAT_SRET-1][ITC_C_SIN]) begin
         next_s.sin_full = 1'b0;
         next_s.sin_ferr = 1'b0;
      end
      if (cp.stage[ITC_LAT_SRET-1][ITC_C_SOUT]) begin
         next_s.sout_empty = 1'b0;
      end
      if (cp.stage[ITC_LAT_SRET-1][ITC_C_OCTL]) begin
         next_s.sout_ferr = 1'b0;
         next_s.scoll = 1'b0;
      end
      next_s.sin_full = next_s.sin_full | serial_input_full_set_i;
      next_s.sin_ferr = next_s.sin_ferr | serial_input_frame_error_set_i;
      next_s.sout_empty = next_s.sout_empty | serial_output_empty_set_i;
      next_s.sout_ferr = next_s.sout_ferr | serial_output_frame_error_set_i;
      next_s.scoll = next_s.scoll | serial_collision_set_i;

      // serial requests stay pending until the longer latency has run out
      for (int k = 0; k < ITC_LAT_SPEND-1; k++) begin
         ser_hold = ser_hold | (|cp.stage[k][ITC_C_SOUT:ITC_C_SIN]);
      end

      // pending bit sources
      for (int u = 0; u < NUNIT; u++) begin
         setv[ITC_B_DIN0 + 2*u] = next_s.din[u];
         setv[ITC_B_DOUT0 + 2*u] = next_s.dout[u];
      end
      setv[ITC_B_EXT +: NEXT] = ext_neg;
      setv[ITC_B_TIM +: 2] = timer_irq_i;
      setv[ITC_B_SIFE] = next_s.sin_ferr | (ser_hold & s.pend[ITC_B_SIFE]);
      setv[ITC_B_SOFE] = next_s.sout_ferr | (ser_hold & s.pend[ITC_B_SOFE]);
      setv[ITC_B_SCOL] = next_s.scoll | (ser_hold & s.pend[ITC_B_SCOL]);
      setv[ITC_B_SIBF] = next_s.sin_full | (ser_hold & s.pend[ITC_B_SIBF]);
      setv[ITC_B_SOBE] = next_s.sout_empty | (ser_hold & s.pend[ITC_B_SOBE]);
      if (trap_neg) begin
         next_s.trap_lat = 1'b1;
      end

      // register writes and reads
      next_s.rdata = '0;
      if (wr_i) begin
         if (addr_i == ITC_A_PEND) begin
            clrv = wdata_i;
         end else if (addr_i == ITC_A_MASK) begin
            next_s.mask = wdata_i & ITC_PEND_VALID;
         end else if (addr_i == ITC_A_AUX) begin
            next_s.stby_req = wdata_i[ITC_STBY_BIT];
            next_s.stby_armed = wdata_i[ITC_STBY_BIT];
         end
      end
      if (rd_i) begin
         if (addr_i == ITC_A_PEND) begin
            next_s.rdata = s.pend;
         end else if (addr_i == ITC_A_MASK) begin
            next_s.rdata = s.mask;
         end else if (addr_i == ITC_A_AUX) begin
            next_s.rdata[ITC_STBY_BIT] = s.stby_req;
         end else if (addr_i == ITC_A_STAT) begin
            next_s.rdata = {8'h00, s.vec, s.trap_lat, s.core_run, 2'(s.fsm)};
         end
      end

      // service sequencer
      case (s.fsm)
         ITC_IDLE: begin
            next_s.vec = ITC_VEC_IDLE;
            if (s.core_run && (s.trap_lat || pick_ok)) begin
               next_s.fsm = ITC_WAIT;
               next_s.cnt = '0;
            end
         end
         ITC_WAIT: begin
            if (s.trap_lat || !core_wait_i) begin
               next_s.cnt = s.cnt + 3'h1;
            end
            if ((s.trap_lat || !core_wait_i) && s.cnt == 3'(ITC_SVC_LAT-1)) begin
               next_s.fsm = ITC_SERVE;
               next_s.ack = 1'b1;
               next_s.cur_trap = s.trap_lat;
               if (s.trap_lat) begin
                  next_s.vec = ITC_VEC_TRAP;
                  next_s.trap_lat = trap_neg;
               end else begin
                  next_s.vec = pick;
                  clrv[pick] = 1'b1;
               end
            end else if (!s.trap_lat && !pick_ok) begin
               next_s.fsm = ITC_IDLE;
            end
         end
         ITC_SERVE: begin
            next_s.ack = 1'b0;
            if (ireturn_i) begin
               next_s.fsm = ITC_IDLE;
               next_s.vec = ITC_VEC_IDLE;
            end
         end
         default: next_s.fsm = ITC_IDLE;
      endcase

      // set wins over clear
      next_s.pend = ((s.pend & ~clrv) | setv) & ITC_PEND_VALID;

      // standby
      if (s.stby_armed && s.core_run && core_instr_i) begin
         next_s.stby_armed = 1'b0;
         next_s.core_run = 1'b0;
      end
      if ((s.stby_req || !s.core_run) && (s.trap_lat || pick_ok)) begin
         next_s.stby_req = 1'b0;
         next_s.stby_armed = 1'b0;
         next_s.core_run = 1'b1;
      end
      next_s.periph_run = 1'b1;
      next_s.trap_oe_n = 1'b1;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s <= '0;
         s.pend <= ITC_PEND_RST;
         s.mask <= ITC_MASK_RST;
         s.fsm <= ITC_IDLE;
         s.vec <= ITC_VEC_IDLE;
         s.core_run <= 1'b1;
         s.periph_run <= 1'b1;
         s.trap_oe_n <= 1'b1;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign rdata_o = s.rdata;
   assign trap_out_o = 1'b0;
   assign trap_oe_n_o = s.trap_oe_n;
   assign vector_code_o = s.vec;
   assign irq_acknowledge_o = s.ack;
   assign core_run_o = s.core_run;
   assign periph_run_o = s.periph_run;
   assign dma_input_full_o = s.din;
   assign dma_output_empty_o = s.dout;
   assign serial_input_full_o = s.sin_full;
   assign serial_output_empty_o = s.sout_empty;

   // ****************************************
   // checks
   // ****************************************
   a_pend_wr_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && wr_i && addr_i == ITC_A_PEND && wdata_i[ITC_B_TIM] && !timer_irq_i[0]
      |=> !s.pend[ITC_B_TIM]) else $error("pending bit not cleared by write");
   a_pend_zero_keep: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && s.pend[ITC_B_TIM] && !(s.fsm == ITC_WAIT) &&
      !(wr_i && addr_i == ITC_A_PEND && wdata_i[ITC_B_TIM]) |=> s.pend[ITC_B_TIM])
      else $error("pending bit lost without clear");
   a_len_latency: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && wr_i && addr_i == ITC_A_DCMD0 && wdata_i[15:12] == ITC_CMD_ILEN
      ##1 ce_i[*3] ##1 (ce_i && !dma_input_full_set_i[0]) |=> !s.din[0])
      else $error("input length update latency wrong");
   a_len_early: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && s.din[0] && wr_i && addr_i == ITC_A_DCMD0 && wdata_i[15:12] == ITC_CMD_ILEN
      ##1 ce_i[*3] |=> s.din[0]) else $error("request dropped too early");
   a_rst_sets_empty: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && wr_i && addr_i == ITC_A_DCMD1 && wdata_i[15:12] == ITC_CMD_RST
      ##1 ce_i[*6] |=> s.dout[1]) else $error("unit reset did not set empty");
   a_serial_ret: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && rd_i && addr_i == ITC_A_DEMUX ##1 (ce_i && !serial_input_full_set_i)
      ##1 (ce_i && !serial_input_full_set_i) |=> !s.sin_full)
      else $error("serial input request not cleared");
   a_vec_idle: assert property (@(posedge clock_i) disable iff (rst_i)
      s.fsm == ITC_IDLE |-> vector_code_o == ITC_VEC_IDLE)
      else $error("vector code not all ones while idle");
   a_ack_entry: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(irq_acknowledge_o) |-> s.fsm == ITC_SERVE && vector_code_o != ITC_VEC_IDLE
      ##1 !irq_acknowledge_o || !ce_i) else $error("acknowledge without vector");
   a_svc_delay: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(irq_acknowledge_o) |-> $past(s.fsm, 4) == ITC_WAIT || !ce_i)
      else $error("service entered too soon");
   a_trap_bound: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && s.fsm == ITC_WAIT && s.trap_lat && s.cnt == 3'h0 && s.core_run
      ##1 ce_i[*3] |=> s.ack) else $error("trap entry too slow");
   a_stby_wake: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && !s.core_run && (s.trap_lat || pick_ok) |=> s.core_run && !s.stby_req)
      else $error("standby not left on trap");
   a_periph_run: assert property (@(posedge clock_i) disable iff (rst_i)
      periph_run_o && trap_oe_n_o) else $error("peripheral clock or trap pin wrong");

endmodule // itc_top

// ---- hw/itc_pkg.sv ----
// package: register map, field positions, latencies and vector codes of the interrupt front end
package itc_pkg;

   // ****************************************
   // register bus
   // ****************************************
   localparam int ITC_AW = 4;
   localparam int ITC_DW = 16;
   localparam logic [3:0] ITC_A_PEND = 4'h0;
   localparam logic [3:0] ITC_A_MASK = 4'h1;
   localparam logic [3:0] ITC_A_DCMD0 = 4'h2;
   localparam logic [3:0] ITC_A_DCMD1 = 4'h3;
   localparam logic [3:0] ITC_A_ICTL = 4'h4;
   localparam logic [3:0] ITC_A_OCTL = 4'h5;
   localparam logic [3:0] ITC_A_DEMUX = 4'h6;
   localparam logic [3:0] ITC_A_OMUX = 4'h7;
   localparam logic [3:0] ITC_A_AUX = 4'h8;
   localparam logic [3:0] ITC_A_STAT = 4'h9;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int ITC_CMD_HI = 15;
   localparam int ITC_CMD_LO = 12;
   localparam logic [3:0] ITC_CMD_ILEN = 4'h4;
   localparam logic [3:0] ITC_CMD_OLEN = 4'h5;
   localparam logic [3:0] ITC_CMD_RST = 4'h6;
   localparam int ITC_FLUSH_BIT = 4;
   localparam int ITC_COLL_BIT = 7;
   localparam int ITC_STBY_BIT = 15;
   localparam logic [15:0] ITC_PEND_RST = 16'h0000;
   localparam logic [15:0] ITC_MASK_RST = 16'h0000;
   localparam logic [15:0] ITC_PEND_VALID = 16'hfffe;

   // pending bit positions, equal to the vector codes
   localparam int ITC_B_DIN0 = 1;
   localparam int ITC_B_DOUT0 = 2;
   localparam int ITC_B_DIN1 = 3;
   localparam int ITC_B_DOUT1 = 4;
   localparam int ITC_B_EXT = 5;
   localparam int ITC_B_TIM = 9;
   localparam int ITC_B_SIFE = 11;
   localparam int ITC_B_SOFE = 12;
   localparam int ITC_B_SCOL = 13;
   localparam int ITC_B_SIBF = 14;
   localparam int ITC_B_SOBE = 15;

   // ****************************************
   // vector codes (trap code value is arbitrary)
   // ****************************************
   localparam logic [3:0] ITC_VEC_IDLE = 4'hf;
   localparam logic [3:0] ITC_VEC_TRAP = 4'h0;

   // ****************************************
   // latencies in clock cycles
   // ****************************************
   localparam int ITC_SVC_LAT = 4;
   localparam int ITC_LAT_LEN = 4;
   localparam int ITC_LAT_DRST = 6;
   localparam int ITC_LAT_SRET = 2;
   localparam int ITC_LAT_SPEND = 4;
   localparam int ITC_PIPE_D = 6;

   // clear event sources fed into the latency pipe
   localparam int ITC_NCLR = 9;
   localparam int ITC_C_ILEN0 = 0;
   localparam int ITC_C_OLEN0 = 1;
   localparam int ITC_C_RST0 = 2;
   localparam int ITC_C_SIN = 6;
   localparam int ITC_C_SOUT = 7;
   localparam int ITC_C_OCTL = 8;
   localparam int ITC_C_UNIT = 3;

   typedef enum logic [1:0] {ITC_IDLE, ITC_WAIT, ITC_SERVE} itc_fsm_t;

endpackage : itc_pkg

// ---- hw/itc_clr_if.sv ----
// interface: clear events into the latency pipe and its delayed stages
interface itc_clr_if #(parameter int W = itc_pkg::ITC_NCLR, parameter int D = itc_pkg::ITC_PIPE_D);
   logic [W-1:0] clr;
   logic [D-1:0][W-1:0] stage;
   modport src (output clr, input stage);
   modport pipe (input clr, output stage);
endinterface : itc_clr_if

// ---- hw/itc_clr_pipe.sv ----
// latency pipe: delays clear events by one stage per enabled clock
module itc_clr_pipe #(
   parameter int W = itc_pkg::ITC_NCLR,
   parameter int D = itc_pkg::ITC_PIPE_D
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   itc_clr_if.pipe cp
);

   typedef struct packed {
      logic [D-1:0][W-1:0] stage;
   } itc_pipe_st_t;

   itc_pipe_st_t s;
   itc_pipe_st_t next_s;

   // ****************************************
   // shift
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.stage[0] = cp.clr;
      for (int i = 1; i < D; i++) begin
         next_s.stage[i] = s.stage[i-1];
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign cp.stage = s.stage;

endmodule // itc_clr_pipe

// ---- tb/itc_src_model.sv ----
// model of the external interrupt and trap sources
module itc_src_model #(
   parameter int HOLD = 2
) (
   input wire logic clock_i,
   input wire logic [4:0] fire_i,
   output logic [3:0] ext_irq_o,
   output logic trap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [5] = '{0, 0, 0, 0, 0};
   // ****
   // each fired pin stands high for HOLD cycles, then low
   // ****
   always @(posedge clock_i) begin
      for (int i = 0; i < 5; i++) begin
         if (fire_i[i]) begin
            cnt[i] <= HOLD;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ext_irq_o[i] = cnt[i] != 0;
      end
      trap_o = cnt[4] != 0;
   end
endmodule // itc_src_model

// ---- tb/tb.sv ----
// self-checking testbench of the interrupt and trap front end
module tb
   import itc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // stimulus and observed signals
   // ****
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0, rd_i = 1'b0, core_wait_i = 1'b0, core_instr_i = 1'b0, ireturn_i = 1'b0;
   logic [1:0] timer_irq_i = 2'h0, din_set = 2'h0, dout_set = 2'h0;
   logic [4:0] ser_set = 5'h00, fire = 5'h00;
   logic [15:0] rdata_o;
   logic [3:0] ext_irq, vector_code_o;
   logic trap_in, trap_out_o, trap_oe_n_o, irq_acknowledge_o, core_run_o, periph_run_o;
   logic [1:0] din_o, dout_o;
   logic sin_o, sout_o;
   int failures = 0, comparisons = 0, n0 = 0;
   always #5 clock_i = ~clock_i;
   itc_src_model u_itc_src_model (.clock_i(clock_i), .fire_i(fire), .ext_irq_o(ext_irq),
      .trap_o(trap_in));
   itc_top u_itc_top (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_i(ext_irq),
      .trap_in_i(trap_in), .trap_out_o(trap_out_o), .trap_oe_n_o(trap_oe_n_o),
      .timer_irq_i(timer_irq_i), .dma_input_full_set_i(din_set),
      .dma_output_empty_set_i(dout_set), .serial_input_full_set_i(ser_set[0]),
      .serial_input_frame_error_set_i(ser_set[1]), .serial_output_empty_set_i(ser_set[2]),
      .serial_output_frame_error_set_i(ser_set[3]), .serial_collision_set_i(ser_set[4]),
      .core_wait_i(core_wait_i), .core_instr_i(core_instr_i), .ireturn_i(ireturn_i),
      .vector_code_o(vector_code_o), .irq_acknowledge_o(irq_acknowledge_o),
      .core_run_o(core_run_o), .periph_run_o(periph_run_o), .dma_input_full_o(din_o),
      .dma_output_empty_o(dout_o), .serial_input_full_o(sin_o), .serial_output_empty_o(sout_o));
   // ****
   // shared tasks
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic sset(input logic [4:0] v);
      @(posedge clock_i);
      ser_set <= v;
      @(posedge clock_i);
      ser_set <= 5'h00;
      cyc(1);
   endtask
   task automatic fire_pin(input logic [4:0] v);
      @(posedge clock_i);
      fire <= v;
      @(posedge clock_i);
      fire <= 5'h00;
   endtask
   task automatic wait_ack(output int n);
      n = 0;
      while (irq_acknowledge_o !== 1'b1) begin
         cyc(1);
         n++;
         if (n > 40) begin
            failures++;
            $display("[ERR] %0t no acknowledge", $time);
            end_of_test();
         end
      end
   endtask
   task automatic ret();
      @(posedge clock_i);
      ireturn_i <= 1'b1;
      @(posedge clock_i);
      ireturn_i <= 1'b0;
      cyc(1);
      chk(vector_code_o, ITC_VEC_IDLE, "vector not idle after return");
   endtask
   task automatic quiet(input string msg);
      int k;
      k = 0;
      repeat (12) begin
         cyc(1);
         if (irq_acknowledge_o !== 1'b0) k++;
      end
      chk(k, 0, msg);
   endtask
   function automatic logic req(input int s);
      logic [4:0] r;
      r = {sout_o, sin_o, din_o[1], dout_o[0], din_o[0]};
      return r[s];
   endfunction
   task automatic lat(input logic [3:0] a, input logic [15:0] d, input int s, input int n);
      wr(a, d);
      cyc(n - 1);
      chk(req(s), 1'b1, "request dropped early");
      cyc(1);
      chk(req(s), 1'b0, "request not dropped");
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      logic [15:0] d;
      chk(vector_code_o, ITC_VEC_IDLE, "idle vector");
      chk({trap_oe_n_o, trap_out_o}, 2'b10, "trap pin not input");
      chk({core_run_o, periph_run_o, irq_acknowledge_o}, 3'b110, "run flags");
      rd(ITC_A_PEND, d);
      chk(d, ITC_PEND_RST, "pending reset value");
      rd(4'hf, d);
      chk(d, 16'h0000, "unmapped read");
      $display("reset test done");
   endtask
   task automatic t_pend();
      logic [15:0] d;
      @(posedge clock_i);
      timer_irq_i <= 2'b01;
      @(posedge clock_i);
      timer_irq_i <= 2'b00;
      cyc(2);
      wr(ITC_A_PEND, 16'h0000);
      rd(ITC_A_PEND, d);
      chk(d[ITC_B_TIM], 1'b1, "pending lost on zero write");
      wr(ITC_A_PEND, 16'h0200);
      rd(ITC_A_PEND, d);
      chk(d[ITC_B_TIM], 1'b0, "pending not cleared");
      $display("pending test done");
   endtask
   task automatic t_dma();
      logic [15:0] d;
      @(posedge clock_i);
      din_set <= 2'b11;
      dout_set <= 2'b01;
      @(posedge clock_i);
      din_set <= 2'b00;
      dout_set <= 2'b00;
      wr(ITC_A_DCMD0, 16'h7000);
      cyc(ITC_LAT_DRST);
      chk(din_o[0], 1'b1, "other command cleared request");
      lat(ITC_A_DCMD0, 16'h4010, 0, ITC_LAT_LEN);
      lat(ITC_A_DCMD0, 16'h5000, 1, ITC_LAT_LEN);
      lat(ITC_A_DCMD1, 16'h6000, 2, ITC_LAT_DRST);
      chk(dout_o[1], 1'b1, "reset command left output empty low");
      wr(ITC_A_PEND, 16'h0008);
      rd(ITC_A_PEND, d);
      chk(d[ITC_B_DIN1], 1'b0, "pending not clearable");
      $display("dma test done");
   endtask
   task automatic t_ser();
      logic [15:0] d;
      sset(5'h03);
      rd(ITC_A_DEMUX, d);
      cyc(ITC_LAT_SRET - 1);
      chk(sin_o, 1'b1, "input request dropped early");
      cyc(1);
      chk(sin_o, 1'b0, "input request kept");
      sset(5'h01);
      wr(ITC_A_ICTL, 16'h0000);
      cyc(ITC_LAT_SPEND);
      chk(sin_o, 1'b1, "plain control write cleared");
      lat(ITC_A_ICTL, 16'h0010, 3, ITC_LAT_SRET);
      sset(5'h04);
      lat(ITC_A_OCTL, 16'h0010, 4, ITC_LAT_SRET);
      sset(5'h04);
      lat(ITC_A_OMUX, 16'h1234, 4, ITC_LAT_SRET);
      sset(5'h18);
      wr(ITC_A_OCTL, 16'h0090);
      cyc(ITC_LAT_SPEND);
      wr(ITC_A_PEND, 16'h3800);
      rd(ITC_A_PEND, d);
      chk(d[13:11], 3'b000, "serial pending not clearable");
      $display("serial test done");
   endtask
   task automatic t_irq();
      logic [15:0] d;
      int n;
      wr(ITC_A_MASK, 16'h0060);
      fire_pin(5'h03);
      wait_ack(n0);
      chk(vector_code_o, 4'h5, "lowest vector not first");
      chk(n0 >= ITC_SVC_LAT + 1, 1'b1, "entry too early");
      cyc(1);
      chk(irq_acknowledge_o, 1'b0, "acknowledge too long");
      rd(ITC_A_PEND, d);
      chk(d[6:5], 2'b10, "pending on entry");
      rd(ITC_A_STAT, d);
      chk(d[7:2], 6'b010101, "status during service");
      ret();
      wait_ack(n);
      chk(vector_code_o, 4'h6, "second vector");
      ret();
      wr(ITC_A_MASK, 16'h0080);
      @(posedge clock_i);
      fire <= 5'h04;
      core_wait_i <= 1'b1;
      @(posedge clock_i);
      fire <= 5'h00;
      quiet("entry during wait states");
      @(posedge clock_i);
      core_wait_i <= 1'b0;
      wait_ack(n);
      chk(n <= n0, 1'b1, "entry late after wait");
      chk(vector_code_o, 4'h7, "vector after wait");
      ret();
      $display("interrupt test done");
   endtask
   task automatic t_trap();
      int n;
      wr(ITC_A_MASK, 16'h0000);
      fire_pin(5'h18);
      wait_ack(n);
      chk(vector_code_o, ITC_VEC_TRAP, "trap vector");
      chk(n <= n0, 1'b1, "trap entry late");
      chk(trap_oe_n_o, 1'b1, "trap pin driven");
      ret();
      quiet("masked interrupt served");
      wr(ITC_A_PEND, 16'h0100);
      $display("trap test done");
   endtask
   task automatic t_stby();
      logic [15:0] d;
      int k;
      wr(ITC_A_MASK, 16'h0100);
      wr(ITC_A_AUX, 16'h8000);
      cyc(3);
      chk(core_run_o, 1'b1, "stopped before last instruction");
      @(posedge clock_i);
      core_instr_i <= 1'b1;
      @(posedge clock_i);
      core_instr_i <= 1'b0;
      cyc(1);
      chk({core_run_o, periph_run_o}, 2'b01, "standby entry");
      @(posedge clock_i);
      din_set <= 2'b01;
      @(posedge clock_i);
      din_set <= 2'b00;
      cyc(10);
      chk({core_run_o, din_o[0]}, 2'b01, "standby run state");
      fire_pin(5'h08);
      k = 0;
      while (core_run_o !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      chk(k < 20, 1'b1, "no wake");
      wait_ack(k);
      chk(vector_code_o, 4'h8, "wake vector");
      rd(ITC_A_AUX, d);
      chk(d[ITC_STBY_BIT], 1'b0, "standby bit kept");
      ret();
      $display("standby test done");
   endtask
   initial begin
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      cyc(2);
      t_reset();
      t_pend();
      t_dma();
      t_ser();
      t_irq();
      t_trap();
      t_stby();
      end_of_test();
   end
endmodule // tb
